// ### core/tspc_pkg.sv
// Shared constants for the touch sensor pin control block.
// Assumes a 100 MHz aclk and an AXI4-Lite master with 8-bit byte addresses.
package tspc_pkg;

  // Clock period of aclk in nanoseconds.
  localparam int CLK_PERIOD_NS = 10;

  // Self-check and calibration time after reset, and its cycle count.
  localparam int CAL_TIME_MS = 120;
  localparam int CAL_CYCLES_DEF = CAL_TIME_MS * 1000000 / CLK_PERIOD_NS;

  // Gap between sensing frames in normal operation.
  localparam int GAP_TIME_US = 10;
  localparam int GAP_CYCLES = GAP_TIME_US * 1000 / CLK_PERIOD_NS;

  // Gap between sensing frames in sleep mode.
  localparam int SLEEP_GAP_TIME_US = 1000;
  localparam int SLEEP_GAP_CYCLES_DEF = SLEEP_GAP_TIME_US * 1000 / CLK_PERIOD_NS;

  // Length of the synchronisation pulse driven on the shared mode line.
  localparam int SYNC_PULSE_TIME_NS = 2000;
  localparam int SYNC_PULSE_CYCLES = SYNC_PULSE_TIME_NS / CLK_PERIOD_NS;

  // Length of one sensing frame.
  localparam int FRAME_TIME_US = 40;
  localparam int FRAME_CYCLES = FRAME_TIME_US * 1000 / CLK_PERIOD_NS;

  // Bound for the mode strap catch after reset; the strap is caught in the first 7 cycles.
  localparam int MODE_CATCH_CYCLES = 8;

  // Number of touch channels.
  localparam logic [3:0] NUM_CH = 4'hC;

  // Strap value that hands channel 1 sensitivity back to the register.
  localparam logic [2:0] STRAP_USE_REG = 3'h3;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam logic [7:0] INFO_OFS = 8'h0C;
  localparam logic [7:0] SENS_LO_OFS = 8'h10;
  localparam logic [7:0] SENS_HI_OFS = 8'h14;
  localparam logic [7:0] RESULT_OFS = 8'h18;

  // Reset value of one channel sensitivity nibble: medium code 011, high/low select 1.
  localparam logic [3:0] SENS_RST_NIBBLE = 4'hB;

  // Serial bus write addresses chosen by the address select pin.
  localparam logic [7:0] BUS_ADDR_LOW = 8'hD0;
  localparam logic [7:0] BUS_ADDR_HIGH = 8'hF0;

  // Status bit positions.
  localparam int STAT_TOUCH = 0;
  localparam int STAT_CAL = 1;
  localparam int STAT_REL = 2;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Positions of the pin inputs in the synchroniser vector.
  localparam int PIN_W = 8;
  localparam int IN_SUSP = 0;
  localparam int IN_BUSEN_N = 1;
  localparam int IN_MODE = 2;
  localparam int IN_ADDR = 3;
  localparam int IN_RST = 4;
  localparam int IN_STRAP = 5;

  // Sensing scheduler phases.
  typedef enum logic [1:0] {
    SY_GAP = 2'b00,
    SY_WAIT = 2'b01,
    SY_PULSE = 2'b10,
    SY_FRAME = 2'b11
  } tspc_phase_e;

endpackage : tspc_pkg

// ### core/tspc_pin_sync.sv
// Three-stage synchroniser for the device pins.
// Assumes pins change asynchronously to aclk; the output follows once stages two and three agree.
`timescale 1ns/10ps
module tspc_pin_sync #(
  parameter int W = tspc_pkg::PIN_W
) (
  // Clock, reset and enable.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Raw pins in, filtered levels out.
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] pin_o
);
  import tspc_pkg::*;

  // All stages kept together; the first stage feeds only the second.
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } tspc_sync_s;

  tspc_sync_s s_q; // Registered stages.
  tspc_sync_s s_d; // Next value of the stages.

  // Shift the pins along and accept a bit only when the last two stages agree.
  always_comb begin
    s_d = s_q;
    s_d.s1 = pin_i;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int i = 0; i < W; i++) begin
      // A single disagreeing sample is treated as a glitch and not passed on.
      if (s_q.s2[i] == s_q.s3[i]) begin
        s_d.o[i] = s_q.s3[i];
      end
    end
  end

  // Synchronous reset clears every stage; the enable freezes them.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign pin_o = s_q.o;

endmodule : tspc_pin_sync

// ### core/tspc_top.sv
// Pin control and readout core of a twelve channel capacitive touch sensor.
// Assumes an AXI4-Lite master on aclk and a sensing front end on aclk that delivers raw samples.
`timescale 1ns/10ps
module tspc_top #(
  parameter int unsigned CAL_CYCLES = tspc_pkg::CAL_CYCLES_DEF,
  parameter int unsigned SLEEP_GAP_CYCLES = tspc_pkg::SLEEP_GAP_CYCLES_DEF
) (
  // Clock, reset and enable.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write channels.
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read channels.
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Device control pins.
  input wire logic sense_suspend_in,
  input wire logic bus_enable_n_in,
  input wire logic reset_pin_in,
  input wire logic address_select_in,
  input wire logic ch1_strap_bit0,
  input wire logic ch1_strap_bit1,
  input wire logic ch1_strap_bit2,
  // Shared mode and synchronisation line.
  input wire logic mode_in,
  output logic mode_o,
  output logic mode_oe,
  // Open-drain outputs.
  output logic irq_pin_o,
  output logic irq_pin_oe,
  output logic channel_one_out,
  output logic channel_one_oe,
  // Sensing front end.
  input wire logic sense_valid,
  input wire logic [3:0] sense_chan,
  input wire logic [7:0] sense_raw,
  output logic sense_run,
  // Level interrupt.
  output logic irq
);
  import tspc_pkg::*;

  // Whole state of the block in one register.
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic sleep;
    logic [1:0] ilc;
    logic [2:0] status;
    logic [2:0] mask;
    logic [47:0] sens;
    logic [11:0][1:0] result;
    logic [11:0][7:0] base;
    logic multi;
    logic calibrating;
    logic [23:0] cal_cnt;
    tspc_phase_e phase;
    logic [23:0] tmr;
    logic run;
    logic mode_drv;
    logic irq;
    logic ch1_low;
    logic zero;
  } tspc_state_s;

  // Value of the state after reset, with calibration armed.
  function automatic tspc_state_s rst_state();
    tspc_state_s r;
    r = '0;
    r.sens = {12{SENS_RST_NIBBLE}};
    r.calibrating = 1'b1;
    r.cal_cnt = 24'(CAL_CYCLES - 1);
    r.tmr = 24'(GAP_CYCLES - 1);
    r.phase = SY_GAP;
    return r;
  endfunction : rst_state

  // Apply write strobes to a register word.
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] stb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (stb[b]) begin
        r[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // Map a delta to a level using the medium code and high/low select.
  function automatic logic [1:0] classify(input logic [7:0] d, input logic [2:0] code, input logic hl);
    logic [8:0] mid;
    logic [8:0] lo;
    logic [8:0] hi;
    mid = {3'h0, code, 3'h0} + 9'h008;
    lo = mid - (mid >> 1'b1 >> 1'b1);
    hi = hl ? mid + (mid >> 1'b1) : mid + (mid >> 1'b1 >> 1'b1);
    if ({1'b0, d} >= hi) begin
      return 2'h3;
    end else if ({1'b0, d} >= mid) begin
      return 2'h2;
    end else if ({1'b0, d} >= lo) begin
      return 2'h1;
    end
    return 2'h0;
  endfunction : classify

  // Whether a level reaches the reporting threshold chosen by the level control field.
  function automatic logic hit(input logic [1:0] lvl, input logic [1:0] ilc);
    unique case (ilc)
      2'h1: return lvl != 2'h0;
      2'h3: return lvl == 2'h3;
      default: return lvl >= 2'h2;
    endcase
  endfunction : hit

  tspc_state_s s_q; // Registered state.
  tspc_state_s s_d; // Next state.
  logic [PIN_W-1:0] pin_sync; // Synchronised pin levels.
  logic susp; // Suspend request.
  logic bus_en; // Bus enable, active when the pin is low.
  logic [2:0] strap; // Channel 1 strap.
  logic [2:0] set_ev; // Events raised this cycle.
  logic [2:0] clr_ev; // Status bits cleared by software this cycle.
  logic [3:0] ch; // Channel of the current sample.
  logic [2:0] code; // Medium code applied to that channel.
  logic hl; // High/low select applied to that channel.
  logic [7:0] delta; // Sample above baseline.
  logic [1:0] lvl; // Classified level.
  logic [1:0] old_lvl; // Level before this sample.
  logic [11:0] busy_ch; // Channels with a nonzero result.
  logic [31:0] wtmp; // Merged word of a narrow register, before its field is taken.

  // All pins cross into aclk through the three-stage filter.
  tspc_pin_sync #(.W(PIN_W)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pin_i({ch1_strap_bit2, ch1_strap_bit1, ch1_strap_bit0, reset_pin_in, address_select_in, mode_in,
            bus_enable_n_in, sense_suspend_in}),
    .pin_o(pin_sync)
  );

  // Next-state logic for the bus slave, scheduler, classifier and interrupt.
  always_comb begin
    s_d = s_q;
    susp = pin_sync[IN_SUSP];
    bus_en = !pin_sync[IN_BUSEN_N];
    strap = pin_sync[IN_STRAP +: 3];
    set_ev = 3'h0;
    clr_ev = 3'h0;
    ch = sense_chan;
    code = 3'h0;
    hl = 1'b0;
    delta = 8'h00;
    lvl = 2'h0;
    old_lvl = 2'h0;
    wtmp = 32'h0;

    // Address and data are taken independently, in either order.
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end

    // Once both halves are held, perform the write and raise the response.
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      if (!bus_en) begin
        // Disabled bus: refused, nothing changes.
        s_d.bresp = RESP_SLVERR;
      end else begin
        unique case (s_q.awaddr)
          CTRL_OFS: begin
            wtmp = wmerge({29'h0, s_q.ilc, s_q.sleep}, s_q.wdata, s_q.wstrb);
            {s_d.ilc, s_d.sleep} = wtmp[2:0];
          end
          STATUS_OFS: begin
            clr_ev = s_q.wdata[2:0] & {3{s_q.wstrb[0]}};
          end
          MASK_OFS: begin
            wtmp = wmerge({29'h0, s_q.mask}, s_q.wdata, s_q.wstrb);
            s_d.mask = wtmp[2:0];
          end
          SENS_LO_OFS: begin
            s_d.sens[31:0] = wmerge(s_q.sens[31:0], s_q.wdata, s_q.wstrb);
          end
          SENS_HI_OFS: begin
            wtmp = wmerge({16'h0, s_q.sens[47:32]}, s_q.wdata, s_q.wstrb);
            s_d.sens[47:32] = wtmp[15:0];
          end
          INFO_OFS, RESULT_OFS: begin
            // Read-only registers ignore writes but answer OKAY.
          end
          default: begin
            s_d.bresp = RESP_SLVERR;
          end
        endcase
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // Read: data is ready one cycle after the address is taken.
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = 32'h0;
      if (!bus_en) begin
        s_d.rresp = RESP_SLVERR;
      end else begin
        unique case (s_axi_araddr)
          CTRL_OFS: s_d.rdata = {29'h0, s_q.ilc, s_q.sleep};
          STATUS_OFS: s_d.rdata = {29'h0, s_q.status};
          MASK_OFS: s_d.rdata = {29'h0, s_q.mask};
          INFO_OFS: s_d.rdata = {18'h0, s_q.calibrating, susp, strap, s_q.multi,
                                 pin_sync[IN_ADDR] ? BUS_ADDR_HIGH : BUS_ADDR_LOW};
          SENS_LO_OFS: s_d.rdata = s_q.sens[31:0];
          SENS_HI_OFS: s_d.rdata = {16'h0, s_q.sens[47:32]};
          RESULT_OFS: s_d.rdata = {8'h0, s_q.result};
          default: s_d.rresp = RESP_SLVERR;
        endcase
      end
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // Calibration countdown; the mode strap is caught in its first cycles.
    if (s_q.calibrating) begin
      if (s_q.cal_cnt > 24'(CAL_CYCLES - MODE_CATCH_CYCLES)) begin
        s_d.multi = !pin_sync[IN_MODE];
      end
      if (s_q.cal_cnt == 24'h0) begin
        s_d.calibrating = 1'b0;
        set_ev[STAT_CAL] = 1'b1;
      end else begin
        s_d.cal_cnt = s_q.cal_cnt - 24'h1;
      end
    end

    // Frame scheduler; multi mode always runs with line synchronisation.
    unique case (s_q.phase)
      SY_GAP: begin
        if (s_q.tmr != 24'h0) begin
          s_d.tmr = s_q.tmr - 24'h1;
        end else if (s_q.multi) begin
          s_d.phase = SY_WAIT;
        end else begin
          s_d.phase = SY_FRAME;
          s_d.tmr = 24'(FRAME_CYCLES - 1);
        end
      end
      SY_WAIT: begin
        // Another chip pulsing keeps the line high; our frame waits for it.
        if (!pin_sync[IN_MODE]) begin
          s_d.phase = SY_PULSE;
          s_d.tmr = 24'(SYNC_PULSE_CYCLES - 1);
          s_d.mode_drv = 1'b1;
        end
      end
      SY_PULSE: begin
        if (s_q.tmr == 24'h0) begin
          s_d.mode_drv = 1'b0;
          s_d.phase = SY_FRAME;
          s_d.tmr = 24'(FRAME_CYCLES - 1);
        end else begin
          s_d.tmr = s_q.tmr - 24'h1;
        end
      end
      SY_FRAME: begin
        if (s_q.tmr == 24'h0) begin
          s_d.phase = SY_GAP;
          // Sleep trades response time for power by stretching the gap.
          s_d.tmr = s_q.sleep ? 24'(SLEEP_GAP_CYCLES - 1) : 24'(GAP_CYCLES - 1);
        end else begin
          s_d.tmr = s_q.tmr - 24'h1;
        end
      end
    endcase
    s_d.run = (s_d.phase == SY_FRAME) && !susp;

    // One sample per valid beat, only inside a running frame.
    if (sense_valid && s_q.run && !susp && sense_chan < NUM_CH) begin
      if (ch == 4'h0 && strap != STRAP_USE_REG) begin
        code = strap;
        hl = 1'b1;
      end else begin
        code = s_q.sens[{ch, 2'b00} +: 3];
        hl = s_q.sens[{ch, 2'b11}];
      end
      delta = (sense_raw > s_q.base[ch]) ? sense_raw - s_q.base[ch] : 8'h00;
      lvl = classify(delta, code, hl);
      old_lvl = s_q.result[ch];
      if (s_q.calibrating) begin
        s_d.base[ch] = sense_raw;
      end else begin
        s_d.result[ch] = lvl;
        // Baseline drifts one step per idle sample, so a slow touch is not absorbed.
        if (lvl == 2'h0 && sense_raw > s_q.base[ch]) begin
          s_d.base[ch] = s_q.base[ch] + 8'h01;
        end else if (lvl == 2'h0 && sense_raw < s_q.base[ch]) begin
          s_d.base[ch] = s_q.base[ch] - 8'h01;
        end
        if (hit(lvl, s_q.ilc) && !hit(old_lvl, s_q.ilc)) begin
          set_ev[STAT_TOUCH] = 1'b1;
        end
        if (lvl == 2'h0 && old_lvl != 2'h0) begin
          set_ev[STAT_REL] = 1'b1;
        end
        // Single output mode keeps only the latest touched channel.
        if (!s_q.multi && lvl != 2'h0) begin
          for (int i = 0; i < 12; i++) begin
            if (4'(i) != ch) begin
              s_d.result[i] = 2'h0;
            end
          end
        end
      end
    end

    // Sticky status: an event in the clearing cycle survives.
    s_d.status = (s_q.status & ~clr_ev) | set_ev;
    s_d.irq = |(s_d.status & s_d.mask);
    s_d.ch1_low = hit(s_d.result[0], s_d.ilc);
    s_d.awready = !s_d.aw_have;
    s_d.wready = !s_d.w_have;
    s_d.arready = !s_d.rvalid;

    // Reset pin holds everything; the mode strap is caught meanwhile.
    if (pin_sync[IN_RST]) begin
      s_d = rst_state();
      s_d.multi = !pin_sync[IN_MODE];
    end
  end

  // State register with synchronous reset and clock enable.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= rst_state();
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register; open-drain data is a constant low.
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign mode_o = s_q.mode_drv;
  assign mode_oe = s_q.mode_drv;
  assign irq_pin_o = s_q.zero;
  assign irq_pin_oe = s_q.irq;
  assign channel_one_out = s_q.zero;
  assign channel_one_oe = s_q.ch1_low;
  assign sense_run = s_q.run;
  assign irq = s_q.irq;

  // Helper for the single-mode check.
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      busy_ch[i] = |s_q.result[i];
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A full-word write to the low sensitivity register with the bus enabled.
  sequence wr_sens_s;
    ce && s_q.aw_have && s_q.w_have && !s_q.bvalid && bus_en && !pin_sync[IN_RST]
      && s_q.awaddr == SENS_LO_OFS && s_q.wstrb == 4'hF;
  endsequence
  // A write while the bus enable pin is high.
  sequence wr_off_s;
    ce && s_q.aw_have && s_q.w_have && !s_q.bvalid && !bus_en && !pin_sync[IN_RST];
  endsequence

  sens_write_a: assert property (wr_sens_s |=> s_q.sens[31:0] == $past(s_q.wdata) && s_q.bvalid)
    else $error("sensitivity write not applied");
  bus_gate_a: assert property (wr_off_s |=> s_q.bvalid && s_q.bresp == RESP_SLVERR)
    else $error("write served while bus disabled");
  suspend_pause_a: assert property (ce && susp |=> !s_q.run)
    else $error("sensing ran while suspended");
  pin_reset_a: assert property (ce && pin_sync[IN_RST] |=> s_q.status == 3'h0 && !s_q.irq && s_q.calibrating)
    else $error("reset pin did not hold reset");
  irq_level_a: assert property (irq_pin_oe |-> !irq_pin_o && s_q.irq == |(s_q.status & s_q.mask))
    else $error("interrupt pin mismatch");
  single_mode_a: assert property (!s_q.multi |-> $onehot0(busy_ch))
    else $error("several channels reported in single mode");
  pulse_multi_a: assert property ($rose(s_q.mode_drv) |-> s_q.multi ##1 s_q.mode_drv)
    else $error("sync pulse outside multi mode");
  cal_quiet_a: assert property (s_q.calibrating |-> s_q.result == '0)
    else $error("touch reported during calibration");

endmodule : tspc_top

// ### testbench/tspc_far_model.sv
// Far side model: pull resistors on the shared mode line and on the open-drain outputs.
// Assumes the design drives mode_o/mode_oe and the open-drain enables from aclk.
`timescale 1ns/10ps
module tspc_far_model #(
  parameter logic PULL_MODE = 1'b1
) (
  // Design side levels and enables.
  input wire logic mode_o,
  input wire logic mode_oe,
  input wire logic irq_pin_oe,
  input wire logic channel_one_oe,
  // Resolved wire levels.
  output logic mode_line,
  output logic irq_line,
  output logic ch1_line
);
  // The mode resistor sets the level whenever no chip drives its pulse.
  assign mode_line = mode_oe ? mode_o : PULL_MODE;
  // Open-drain pins only pull low, so the host pull-up gives the high level.
  assign irq_line = irq_pin_oe ? 1'b0 : 1'b1;
  assign ch1_line = channel_one_oe ? 1'b0 : 1'b1;
endmodule : tspc_far_model

// ### testbench/tspc_top_tb_top.sv
// Self-checking bench for the touch sensor pin control core.
// Assumes tspc_top on a 100 MHz aclk, with short calibration and sleep counts.
`timescale 1ns/10ps
module tspc_top_tb_top;
  import tspc_pkg::*;
  // Bus, pin and front end signals.
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, raw;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, resp;
  logic [3:0] wstrb, chan;
  logic susp, bus_en_n, rpin, asel, sb0, sb1, sb2, mode_o, mode_oe, mode_line, ipo, ipoe, c1o, c1oe;
  logic svalid, srun, irq, irq_line, ch1_line;
  int err_count, compares;
  // Short calibration keeps the run brief; thresholds do not depend on it.
  tspc_top #(.CAL_CYCLES(64), .SLEEP_GAP_CYCLES(50)) i_tspc_top (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .sense_suspend_in(susp), .bus_enable_n_in(bus_en_n), .reset_pin_in(rpin),
    .address_select_in(asel), .ch1_strap_bit0(sb0), .ch1_strap_bit1(sb1), .ch1_strap_bit2(sb2),
    .mode_in(mode_line), .mode_o(mode_o), .mode_oe(mode_oe), .irq_pin_o(ipo), .irq_pin_oe(ipoe),
    .channel_one_out(c1o), .channel_one_oe(c1oe), .sense_valid(svalid), .sense_chan(chan),
    .sense_raw(raw), .sense_run(srun), .irq(irq));
  // Pull resistors on the shared lines.
  tspc_far_model #(.PULL_MODE(1'b1)) i_tspc_far_model (
    .mode_o(mode_o), .mode_oe(mode_oe), .irq_pin_oe(ipoe), .channel_one_oe(c1oe),
    .mode_line(mode_line), .irq_line(irq_line), .ch1_line(ch1_line));
  // Free-running 100 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("Mismatches %0d, comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // A wait that ran out ends the run as a mismatch.
  task automatic hang();
    err_count++;
    $display("Error at %0t: wait ran out", $time);
    give_verdict();
  endtask : hang
  // Compares one value with case inequality, so an unknown never matches.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One write; each channel is released at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    bready <= 1'b1;
    repeat (300) begin
      if (!got) begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) begin
          got = 1'b1;
          bready <= 1'b0;
          resp = bresp;
        end
      end
    end
    if (!got) hang();
  endtask : wr
  // One read; data and response are taken at the rvalid edge.
  task automatic rd(input logic [7:0] a);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    repeat (300) begin
      if (!got) begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
        if (rvalid) begin
          got = 1'b1;
          rready <= 1'b0;
          d = rdata;
          resp = rresp;
        end
      end
    end
    if (!got) hang();
  endtask : rd
  // Hands one sample to the core inside a sensing frame.
  task automatic sample(input logic [3:0] c, input logic [7:0] r);
    int n;
    n = 0;
    while (!srun && n < 6000) begin
      @(posedge aclk);
      n++;
    end
    if (!srun) hang();
    svalid <= 1'b1;
    chan <= c;
    raw <= r;
    @(posedge aclk);
    svalid <= 1'b0;
    repeat (3) @(posedge aclk);
    rd(RESULT_OFS);
  endtask : sample
  // Reset values of the sensitivity registers and an unmapped offset.
  task automatic sc_reset_values();
    rd(SENS_LO_OFS);
    chk(d, 32'hBBBBBBBB);
    rd(SENS_HI_OFS);
    chk(d, 32'h0000BBBB);
    rd(8'h40);
    chk(32'(resp), 32'(RESP_SLVERR));
  endtask : sc_reset_values
  // Both address select levels, the strap and the output mode.
  task automatic sc_info();
    for (int s = 1; s >= 0; s--) begin
      asel <= s[0];
      repeat (6) @(posedge aclk);
      rd(INFO_OFS);
      chk(32'(d[7:0]), 32'(s[0] ? BUS_ADDR_HIGH : BUS_ADDR_LOW));
      chk(32'(d[11:8]), 32'h6);
    end
  endtask : sc_info
  // A disabled bus refuses both directions and changes nothing.
  task automatic sc_bus_enable();
    bus_en_n <= 1'b1;
    repeat (6) @(posedge aclk);
    wr(MASK_OFS, 32'h1);
    chk(32'(resp), 32'(RESP_SLVERR));
    rd(MASK_OFS);
    chk({d[29:0], resp}, 32'(RESP_SLVERR));
    bus_en_n <= 1'b0;
    repeat (6) @(posedge aclk);
    rd(MASK_OFS);
    chk({d[29:0], resp}, 32'(RESP_OKAY));
  endtask : sc_bus_enable
  // Calibration ends, then the interrupt is masked, unmasked and cleared.
  task automatic sc_cal_irq();
    d = 32'h2000;
    for (int n = 0; n < 200 && d[13]; n++) rd(INFO_OFS);
    if (d[13]) hang();
    rd(STATUS_OFS);
    chk(32'(d[STAT_CAL]), 32'h1);
    chk({irq, irq_line}, 32'h1);
    wr(MASK_OFS, 32'h2);
    repeat (3) @(posedge aclk);
    chk({irq, irq_line}, 32'h2);
    wr(STATUS_OFS, 32'h2);
    repeat (3) @(posedge aclk);
    chk({irq, irq_line}, 32'h1);
  endtask : sc_cal_irq
  // Suspend pauses the sensing frames.
  task automatic sc_suspend();
    susp <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(32'(srun), 32'h0);
    rd(INFO_OFS);
    chk(32'(d[12]), 32'h1);
    susp <= 1'b0;
  endtask : sc_suspend
  // Reset code 3 with HL set gives thresholds 24, 32 and 48; strap 111 raises them to 48, 64, 96.
  task automatic sc_touch();
    sample(4'h0, 8'd40);
    chk(32'(d[1:0]), 32'h2);
    chk({c1oe, ch1_line}, 32'h2);
    sample(4'h1, 8'd30);
    chk(32'(d[3:0]), 32'h4);
    sample(4'h1, 8'd40);
    chk(32'(d[3:2]), 32'h2);
    sample(4'h1, 8'd60);
    chk(32'(d[3:2]), 32'h3);
    sb2 <= 1'b1;
    repeat (6) @(posedge aclk);
    sample(4'h0, 8'd40);
    chk(32'(d[1:0]), 32'h0);
    chk({c1oe, ch1_line}, 32'h1);
  endtask : sc_touch
  // The reset pin stalls the bus and restarts calibration.
  task automatic sc_pin_reset();
    rpin <= 1'b1;
    repeat (8) @(posedge aclk);
    chk(32'(arready), 32'h0);
    rpin <= 1'b0;
    repeat (8) @(posedge aclk);
    rd(INFO_OFS);
    chk(32'(d[13]), 32'h1);
    rd(RESULT_OFS);
    chk(d, 32'h0);
  endtask : sc_pin_reset
  // Main sequence: reset for two cycles, then every scenario in turn.
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, svalid, susp, bus_en_n, rpin, asel, sb2} = '0;
    {awaddr, araddr, raw, wdata, chan, err_count, compares} = '0;
    {sb0, sb1, wstrb} = 6'h3F;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    sc_reset_values();
    sc_info();
    sc_bus_enable();
    sc_cal_irq();
    sc_suspend();
    sc_touch();
    sc_pin_reset();
    give_verdict();
  end
endmodule : tspc_top_tb_top
